// ---- lcd_analog_shared_io_ports.sv ----
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "lcd_io_defines.svh"


module lcd_analog_shared_io_ports (
    // Clock and reset.
    input  wire logic                   CLK,
    input  wire logic                   RESETN,
    // APB slave.
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [11:0]            PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    // Port 5 pins and segment data.
    input  wire logic [7:0]             P5_PIN_IN,
    input  wire logic [7:0]             P5_SEG_DATA,
    output lcd_io_pkg::pin_drive_t      P5_DRIVE,
    // Port 6 pins.
    input  wire logic [7:0]             P6_PIN_IN,
    output lcd_io_pkg::pin_drive_t      P6_DRIVE,
    // Port 6 taps: interrupt, counter and key wake-up inputs.
    output logic      [7:0]             P6_FUNC_IN,
    // Port 6 analog switch select for the converter.
    output logic      [7:0]             P6_ANALOG_SEL,
    // Port 7 pins and segment data.
    input  wire logic [7:0]             P7_PIN_IN,
    input  wire logic [7:0]             P7_SEG_DATA,
    output lcd_io_pkg::pin_drive_t      P7_DRIVE
);
    import lcd_io_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Maps a byte address to a register; misaligned addresses miss.
    function automatic reg_sel_t decode(input logic [11:0] addr);
        reg_sel_t   sel;
        logic [9:0] idx;
        sel = SEL_NONE;
        idx = addr[11:2];
        if (addr[1:0] == `BYTE_ALIGN) begin
            case (idx)
                `IDX_P5_LATCH:  sel = SEL_P5_LATCH;
                `IDX_P5_PIN:    sel = SEL_P5_PIN;
                `IDX_P5_SEGSEL: sel = SEL_P5_SEGSEL;
                `IDX_P6_LATCH:  sel = SEL_P6_LATCH;
                `IDX_P6_DIR:    sel = SEL_P6_DIR;
                `IDX_P7_LATCH:  sel = SEL_P7_LATCH;
                `IDX_P7_PIN:    sel = SEL_P7_PIN;
                `IDX_P7_SEGSEL: sel = SEL_P7_SEGSEL;
                `IDX_CONV_CTRL: sel = SEL_CONV_CTRL;
                default:        sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    reg_sel_t   wr_sel;
    reg_sel_t   rd_sel;
    logic       wr_fire;
    logic [7:0] wbyte;

    // A write lands at the edge that completes the access phase.
    // Writes to the pin-input registers decode but change nothing.
    assign wr_fire = PSEL & PENABLE & PWRITE & PREADY;
    assign wr_sel  = wr_fire ? decode(PADDR) : SEL_NONE;
    assign rd_sel  = decode(PADDR);
    assign wbyte   = PWDATA[7:0];

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    // Pin levels are asynchronous, so each port passes a settling chain.
    logic [7:0] p5_level;
    logic [7:0] p6_level;
    logic [7:0] p7_level;

    pin_sync #(.WIDTH(8)) u_sync_p5 (
        .clk          (CLK),
        .resetn       (RESETN),
        .pin_async    (P5_PIN_IN),
        .pin_sync_out (p5_level)
    );

    pin_sync #(.WIDTH(8)) u_sync_p6 (
        .clk          (CLK),
        .resetn       (RESETN),
        .pin_async    (P6_PIN_IN),
        .pin_sync_out (p6_level)
    );

    pin_sync #(.WIDTH(8)) u_sync_p7 (
        .clk          (CLK),
        .resetn       (RESETN),
        .pin_async    (P7_PIN_IN),
        .pin_sync_out (p7_level)
    );

    // ****************************************************************
    // Ports 5 and 7
    // ****************************************************************

    logic [7:0] p5_latch;
    logic [7:0] p5_segsel;
    logic [7:0] p7_latch;
    logic [7:0] p7_segsel;

    lcd_port u_port5 (
        .clk       (CLK),
        .resetn    (RESETN),
        .wr_latch  (wr_sel == SEL_P5_LATCH),
        .wr_segsel (wr_sel == SEL_P5_SEGSEL),
        .wdata     (wbyte),
        .seg_data  (P5_SEG_DATA),
        .latch_r   (p5_latch),
        .segsel_r  (p5_segsel),
        .drive_r   (P5_DRIVE)
    );

    lcd_port u_port7 (
        .clk       (CLK),
        .resetn    (RESETN),
        .wr_latch  (wr_sel == SEL_P7_LATCH),
        .wr_segsel (wr_sel == SEL_P7_SEGSEL),
        .wdata     (wbyte),
        .seg_data  (P7_SEG_DATA),
        .latch_r   (p7_latch),
        .segsel_r  (p7_segsel),
        .drive_r   (P7_DRIVE)
    );

    // ****************************************************************
    // Port 6 registers
    // ****************************************************************

    logic [7:0] p6_latch_r;
    logic [7:0] p6_dir_r;
    logic       analog_input_disable_r;
    logic       conv_start_r;

    // Port 6 output latch, cleared by reset.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p6_latch_r <= `P6_RST;
        end else if (wr_sel == SEL_P6_LATCH) begin
            p6_latch_r <= wbyte;
        end
    end

    // Port 6 direction, one bit per pin, cleared by reset.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p6_dir_r <= `P6_RST;
        end else if (wr_sel == SEL_P6_DIR) begin
            p6_dir_r <= wbyte;
        end
    end

    // Converter control: analog disable sets on reset, start clears.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            analog_input_disable_r <= `CONV_DISABLE_RST;
            conv_start_r           <= `CONV_START_RST;
        end else if (wr_sel == SEL_CONV_CTRL) begin
            analog_input_disable_r <= wbyte[`CONV_DISABLE_BIT];
            conv_start_r           <= wbyte[`CONV_START_BIT];
        end
    end

    // ****************************************************************
    // Port 6 mode decode
    // ****************************************************************

    logic [7:0] p6_out_mode;
    logic [7:0] p6_in_mode;
    logic [7:0] p6_analog_mode;

    // Mode per bit from direction, latch and analog disable.
    always_comb begin
        p6_out_mode    = p6_dir_r;
        p6_in_mode     = ~p6_dir_r & p6_latch_r;
        p6_analog_mode = ~p6_dir_r & ~p6_latch_r
                       & {8{~analog_input_disable_r}};
    end

    // Output bits drive the latch; other bits release the pin.
    // The level is masked by direction so a released pin never shows one.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            P6_DRIVE <= '0;
        end else begin
            P6_DRIVE.level  <= p6_latch_r & p6_out_mode;
            P6_DRIVE.enable <= p6_out_mode;
        end
    end

    // Digital taps follow the pin only in input mode, zero otherwise.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            P6_FUNC_IN <= `P6_RST;
        end else begin
            P6_FUNC_IN <= p6_level & p6_in_mode;
        end
    end

    // Analog switches close only once a conversion is started.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            P6_ANALOG_SEL <= `P6_RST;
        end else begin
            P6_ANALOG_SEL <= p6_analog_mode & {8{conv_start_r}};
        end
    end

    // ****************************************************************
    // APB read path and response
    // ****************************************************************

    logic [7:0] p6_read;
    logic [7:0] rd_byte;
    logic [7:0] conv_byte;

    // Port 6 read: latch for outputs, pin for inputs, zero for analog.
    // A read-modify-write would copy pin levels into the latch.
    always_comb begin
        p6_read = (p6_latch_r & p6_out_mode)
                | (p6_level & ~p6_out_mode & ~p6_analog_mode);
        p6_read = p6_read & ~p6_analog_mode;
    end

    // Converter control readback, each flag at its own field position.
    always_comb begin
        conv_byte                    = 8'h00;
        conv_byte[`CONV_DISABLE_BIT] = analog_input_disable_r;
        conv_byte[`CONV_START_BIT]   = conv_start_r;
    end

    // Read multiplexer; segment pins read their settled pin level.
    always_comb begin
        case (rd_sel)
            SEL_P5_LATCH:  rd_byte = p5_latch;
            SEL_P5_PIN:    rd_byte = p5_level;
            SEL_P5_SEGSEL: rd_byte = p5_segsel;
            SEL_P6_LATCH:  rd_byte = p6_read;
            SEL_P6_DIR:    rd_byte = p6_dir_r;
            SEL_P7_LATCH:  rd_byte = p7_latch;
            SEL_P7_PIN:    rd_byte = p7_level;
            SEL_P7_SEGSEL: rd_byte = p7_segsel;
            SEL_CONV_CTRL: rd_byte = conv_byte;
            default:       rd_byte = 8'h00;
        endcase
    end

    // Ready rises for the first access cycle, then drops again.
    // Every transfer thus has exactly one access cycle, and a setup that
    // follows an access at once is still seen as a fresh request.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
        end
    end

    // Read data and error are captured in the setup cycle.
    // Read data then stands until the next setup; the error flag is
    // raised only for the one access cycle that carries ready.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            PRDATA  <= `WORD_ZERO;
            PSLVERR <= 1'b0;
        end else if (PSEL & ~PENABLE) begin
            PRDATA  <= PWRITE ? `WORD_ZERO : {24'h000000, rd_byte};
            PSLVERR <= (rd_sel == SEL_NONE);
        end else begin
            PSLVERR <= 1'b0;
        end
    end

endmodule

// ---- lcd_analog_shared_io_ports_bench.sv ----
`timescale 1ns/1ps
`include "lcd_io_defines.svh"

module lcd_analog_shared_io_ports_bench;
    import lcd_io_pkg::*;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  p5_seg, p7_seg, p5_pin, p6_pin, p7_pin, p6_func, p6_asel;
    logic [7:0]  p5_ext, p6_ext, p7_ext;
    logic        rerr;
    pin_drive_t  p5_drv, p6_drv, p7_drv;
    int err_total, cmp_count;
    logic [9:0] ri [6] = '{`IDX_P5_LATCH, `IDX_P5_SEGSEL, `IDX_P7_LATCH,
                           `IDX_P7_SEGSEL, `IDX_P6_DIR, `IDX_CONV_CTRL};
    logic [7:0] rv [6] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h01};

    lcd_analog_shared_io_ports lcd_analog_shared_io_ports_inst (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .P5_PIN_IN(p5_pin),
        .P5_SEG_DATA(p5_seg), .P5_DRIVE(p5_drv), .P6_PIN_IN(p6_pin),
        .P6_DRIVE(p6_drv), .P6_FUNC_IN(p6_func), .P6_ANALOG_SEL(p6_asel),
        .P7_PIN_IN(p7_pin), .P7_SEG_DATA(p7_seg), .P7_DRIVE(p7_drv));

    pin_world pin_world_inst (
        .p5_drive(p5_drv), .p6_drive(p6_drv), .p7_drive(p7_drv),
        .p5_ext(p5_ext), .p6_ext(p6_ext), .p7_ext(p7_ext),
        .p5_pin(p5_pin), .p6_pin(p6_pin), .p7_pin(p7_pin));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'h0};
    endfunction

    // Counts and reports one value comparison.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rdat, {24'h000000, e});
        chk({31'h0, rerr}, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        #100us;
        err_total++;
        print_verdict;
    end

    // Main sequence of register calls and pin checks.
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        p5_seg = 8'hFF;
        p7_seg = 8'h0F;
        p5_ext = 8'hA5;
        p6_ext = 8'h3C;
        p7_ext = 8'h5A;
        err_total = 0;
        cmp_count = 0;
        settle(20);
        resetn <= 1'b1;
        settle(8);
        for (int i = 0; i < 6; i++)
            rd(ba(ri[i]), rv[i]);
        chk({16'h0, p5_drv | p7_drv | p6_drv}, 32'h0);
        rd(ba(`IDX_P5_PIN), 8'hA5);
        rd(ba(`IDX_P7_PIN), 8'h5A);
        apb(1'b0, 12'hFFC, 8'h00);
        chk({rdat[30:0], rerr}, 32'h1);
        apb(1'b1, ba(`IDX_P5_LATCH) | 12'h2, 8'h00);
        chk({31'h0, rerr}, 32'h1);
        rd(ba(`IDX_P5_LATCH), 8'hFF);
        // Release the low nibble so it can serve as input.
        apb(1'b1, ba(`IDX_P5_LATCH), 8'h0F);
        settle(8);
        chk({16'h0, p5_drv}, 32'h00F0);
        rd(ba(`IDX_P5_LATCH), 8'h0F);
        rd(ba(`IDX_P5_PIN), 8'h05);
        apb(1'b1, ba(`IDX_P5_SEGSEL), 8'h81);
        settle(3);
        chk({16'h0, p5_drv}, 32'h81F1);
        apb(1'b1, ba(`IDX_P5_SEGSEL), 8'h00);
        settle(3);
        chk({16'h0, p5_drv}, 32'h00F0);
        apb(1'b1, ba(`IDX_P7_SEGSEL), 8'hFF);
        settle(3);
        chk({16'h0, p7_drv}, 32'h0FFF);
        rd(ba(`IDX_P7_SEGSEL), 8'hFF);
        apb(1'b1, ba(`IDX_P7_LATCH), 8'h3C);
        rd(ba(`IDX_P7_LATCH), 8'h3C);
        apb(1'b1, ba(`IDX_P7_SEGSEL), 8'h0F);
        settle(3);
        chk({16'h0, p7_drv}, 32'h0FCF);
        apb(1'b1, ba(`IDX_P6_DIR), 8'h0F);
        apb(1'b1, ba(`IDX_P6_LATCH), 8'h15);
        settle(8);
        chk({16'h0, p6_drv}, 32'h050F);
        rd(ba(`IDX_P6_DIR), 8'h0F);
        rd(ba(`IDX_P6_LATCH), 8'h35);
        chk({24'h0, p6_func}, 32'h10);
        apb(1'b1, ba(`IDX_CONV_CTRL), 8'h00);
        settle(3);
        rd(ba(`IDX_P6_LATCH), 8'h15);
        chk({24'h0, p6_asel}, 32'h00);
        apb(1'b1, ba(`IDX_CONV_CTRL), 8'h02);
        settle(3);
        chk({24'h0, p6_asel}, 32'hE0);
        chk({24'h0, p6_func}, 32'h10);
        print_verdict;
    end
endmodule

// ---- lcd_io_defines.svh ----
`ifndef LCD_IO_DEFINES_SVH
`define LCD_IO_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_P5_LATCH     10'h005
`define IDX_P5_PIN       10'h00B
`define IDX_P5_SEGSEL    10'h02A
`define IDX_P6_LATCH     10'h006
`define IDX_P6_DIR       10'h00C
`define IDX_P7_LATCH     10'h007
`define IDX_P7_PIN       10'h00D
`define IDX_P7_SEGSEL    10'h02B
`define IDX_CONV_CTRL    10'h00E

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CONV_DISABLE_BIT 0
`define CONV_DISABLE_RST 1'h1
`define CONV_START_RST   1'h0
`define CONV_START_BIT   1
`define LATCH_ONES_RST   8'hFF
`define SEGSEL_RST       8'h00
`define P6_RST           8'h00
`define WORD_ZERO        32'h0000_0000
`define BYTE_ALIGN       2'h0

`endif

// ---- lcd_io_pkg.sv ----
package lcd_io_pkg;

    // Pin drive of one eight-bit port: level and output enable.
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pin_drive_t;

    // Register selected by an APB address.
    typedef enum logic [3:0] {
        SEL_NONE      = 4'h0,
        SEL_P5_LATCH  = 4'h1,
        SEL_P5_PIN    = 4'h3,
        SEL_P5_SEGSEL = 4'h2,
        SEL_P6_LATCH  = 4'h6,
        SEL_P6_DIR    = 4'h7,
        SEL_P7_LATCH  = 4'h5,
        SEL_P7_PIN    = 4'h4,
        SEL_P7_SEGSEL = 4'hC,
        SEL_CONV_CTRL = 4'hD
    } reg_sel_t;

endpackage

// ---- lcd_io_ports_props.sv ----
`timescale 1ns/1ps

// Port relations watched on the top module of the port block.
module io_ports_props (
    // Clock and reset.
    input wire logic                   CLK,
    input wire logic                   RESETN,
    // APB slave side.
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic [31:0]            PRDATA,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    // Pin side.
    input wire lcd_io_pkg::pin_drive_t P5_DRIVE,
    input wire lcd_io_pkg::pin_drive_t P6_DRIVE,
    input wire logic [7:0]             P6_FUNC_IN,
    input wire logic [7:0]             P6_ANALOG_SEL,
    input wire lcd_io_pkg::pin_drive_t P7_DRIVE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    AST_READY_AFTER_SETUP: assert property (
        PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
    AST_READY_ONE: assert property (
        PREADY |=> !PREADY) else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (
        PSLVERR |-> PREADY) else $error("error without ready");
    AST_UPPER_ZERO: assert property (
        PREADY |-> PRDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_RESET_DRIVE: assert property (
        $rose(RESETN) |-> P5_DRIVE == 16'h0000 && P7_DRIVE == 16'h0000
        && P6_DRIVE == 16'h0000) else $error("pins driven after reset");
    AST_RESET_TAPS: assert property (
        $rose(RESETN) |-> P6_FUNC_IN == 8'h00 && P6_ANALOG_SEL == 8'h00)
        else $error("port 6 inputs not zero after reset");
    AST_P6_LEVEL: assert property (
        (P6_DRIVE.level & ~P6_DRIVE.enable) == 8'h00)
        else $error("level on an undriven port 6 pin");
    AST_ANALOG_NOT_OUT: assert property (
        (P6_ANALOG_SEL & P6_DRIVE.enable) == 8'h00)
        else $error("analog select on an output pin");
endmodule

bind lcd_analog_shared_io_ports io_ports_props io_ports_props_inst (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .P5_DRIVE(P5_DRIVE), .P6_DRIVE(P6_DRIVE), .P6_FUNC_IN(P6_FUNC_IN),
    .P6_ANALOG_SEL(P6_ANALOG_SEL), .P7_DRIVE(P7_DRIVE));

// ---- lcd_port.sv ----
`timescale 1ns/1ps
`include "lcd_io_defines.svh"

module lcd_port (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // Register writes from the bus slave.
    input  wire logic                   wr_latch,
    input  wire logic                   wr_segsel,
    input  wire logic [7:0]             wdata,
    // Segment data from the LCD driver.
    input  wire logic [7:0]             seg_data,
    // Register contents and pin drive.
    output logic      [7:0]             latch_r,
    output logic      [7:0]             segsel_r,
    output lcd_io_pkg::pin_drive_t      drive_r
);
    import lcd_io_pkg::*;

    // Output latch, all ones after reset.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            latch_r <= `LATCH_ONES_RST;
        end else if (wr_latch) begin
            latch_r <= wdata;
        end
    end

    // Per-bit segment select, cleared by reset.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            segsel_r <= `SEGSEL_RST;
        end else if (wr_segsel) begin
            segsel_r <= wdata;
        end
    end

    // Segment bits drive the LCD data; port bits sink low on a zero
    // latch and release the pin on a one so it can serve as input.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_r <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (segsel_r[i]) begin
                    drive_r.level[i]  <= seg_data[i];
                    drive_r.enable[i] <= 1'b1;
                end else begin
                    drive_r.level[i]  <= 1'b0;
                    drive_r.enable[i] <= ~latch_r[i];
                end
            end
        end
    end

endmodule

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`include "lcd_io_defines.svh"

module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             resetn,
    // Asynchronous pin levels in, settled levels out.
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // Three-stage chain; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage1_r <= pin_async;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // A bit changes only once the second and third stages agree.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_agree
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pin_sync_out[i] <= 1'b0;
                end else if (stage2_r[i] == stage3_r[i]) begin
                    pin_sync_out[i] <= stage3_r[i];
                end
            end
        end
    endgenerate

endmodule

// ---- pin_world.sv ----
`timescale 1ns/1ps

// Outside world of the pins: a driven bit shows the device level,
// a released bit shows what the outside source puts on it.
module pin_world (
    // Drives from the device.
    input  wire lcd_io_pkg::pin_drive_t p5_drive,
    input  wire lcd_io_pkg::pin_drive_t p6_drive,
    input  wire lcd_io_pkg::pin_drive_t p7_drive,
    // Outside source levels.
    input  wire logic [7:0]             p5_ext,
    input  wire logic [7:0]             p6_ext,
    input  wire logic [7:0]             p7_ext,
    // Resolved pin levels.
    output logic      [7:0]             p5_pin,
    output logic      [7:0]             p6_pin,
    output logic      [7:0]             p7_pin
);
    // Each pin is bidirectional, so device drive wins where enabled.
    assign p5_pin = (p5_drive.enable & p5_drive.level)
                  | (~p5_drive.enable & p5_ext);
    assign p6_pin = (p6_drive.enable & p6_drive.level)
                  | (~p6_drive.enable & p6_ext);
    assign p7_pin = (p7_drive.enable & p7_drive.level)
                  | (~p7_drive.enable & p7_ext);
endmodule
